// >>> hw/anf_pkg.sv
// package: constants for the nine-bit fifo host controller
package anf_pkg;
  localparam int unsigned ANF_WORD_W   = 9;
  localparam int unsigned ANF_DEPTH    = 1024;
  localparam int unsigned ANF_CLK_MHZ  = 10;
  // strobe low and high phase, ns (host choice, slowest grade is 100 ns)
  localparam int unsigned ANF_STB_NS   = 200;
  localparam int unsigned ANF_STB_CYC  =
    (ANF_STB_NS * ANF_CLK_MHZ + 999) / 1000;
  // reset and rewind pulse width, ns
  localparam int unsigned ANF_RST_NS   = 500;
  localparam int unsigned ANF_RST_CYC  =
    (ANF_RST_NS * ANF_CLK_MHZ + 999) / 1000;
  // extra strobe-high cycles so a flag change clears the synchroniser
  // before the sequencer decides on the next cycle
  localparam int unsigned ANF_SYNC_CYC = 3;
  localparam int unsigned ANF_CNT_W    = 8;
  localparam logic [7:0]  ANF_ONE      = 8'h01;
  localparam logic [7:0]  ANF_ZERO     = 8'h00;
  typedef enum logic [2:0] {
    ANF_ST_RESET, ANF_ST_IDLE, ANF_ST_WLOW, ANF_ST_RLOW,
    ANF_ST_RWLOW, ANF_ST_HIGH
  } anf_state_e;
endpackage

// >>> hw/anf_skid.sv
// two-entry valid/ready buffer for read words
`timescale 1ns/1ps
`default_nettype none
module anf_skid #(
  parameter int unsigned W = 9
) (
  input  wire logic         mclk_i,    // clock
  input  wire logic         sys_rst_i, // sync reset
  input  wire logic [W-1:0] in_data_i, // fill word
  input  wire logic         in_valid_i,// fill valid
  output logic              in_ready_o,// room for a word
  output logic [W-1:0]      out_data_o,// drain word
  output logic              out_valid_o,// drain valid
  input  wire logic         out_ready_i // drain ready
);
  logic [W-1:0] out_reg;
  logic         out_vld_reg;
  logic [W-1:0] spill_reg;
  logic         spill_vld_reg;
  logic         push;
  logic         load;

  assign push        = in_valid_i && in_ready_o;
  // output slot takes a word when empty or drained this cycle
  assign load        = !out_vld_reg || out_ready_i;
  // ready comes from a flop, so the filler sees no path from the drain
  assign in_ready_o  = !spill_vld_reg;
  assign out_data_o  = out_reg;
  assign out_valid_o = out_vld_reg;

  always_ff @(posedge mclk_i) begin
    if (load) begin
      if (spill_vld_reg) begin
        out_reg <= spill_reg;
      end else if (push) begin
        out_reg <= in_data_i;
      end
    end
    if (push && !load) begin
      spill_reg <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      out_vld_reg   <= 1'b0;
      spill_vld_reg <= 1'b0;
    end else if (load) begin
      out_vld_reg   <= spill_vld_reg || push;
      spill_vld_reg <= 1'b0;
    end else if (push) begin
      spill_vld_reg <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> hw/anf_host.sv
// host controller that drives an asynchronous nine-bit fifo by its pins
// Overview of operation
// - host resets the device after power-up before any write
// - host holds both strobes high throughout reset
// - host keeps both strobes high during a rewind
// - first-load low marks first device in a cascade chain
`timescale 1ns/1ps
`default_nettype none
module anf_host
  import anf_pkg::*;
#(
  parameter int unsigned WORD_W = ANF_WORD_W
) (
  input  wire logic              mclk_i,        // 10 MHz clock
  input  wire logic              sys_rst_i,     // sync reset, high
  // user side
  input  wire logic [WORD_W-1:0] push_data_i,   // word to write
  input  wire logic              push_valid_i,  // write request
  output logic                   push_ready_o,  // write accepted
  output logic [WORD_W-1:0]      pop_data_o,    // word read
  output logic                   pop_valid_o,   // read word valid
  input  wire logic              pop_ready_i,   // user takes word
  input  wire logic              rewind_req_i,  // rewind request pulse
  input  wire logic              clear_req_i,   // device reset request
  input  wire logic              single_mode_i, // tie cascade low
  output logic                   empty_o,       // device empty
  output logic                   full_o,        // device full
  output logic                   half_o,        // device past half
  output logic                   busy_o,        // cycle in progress
  // device pins
  output logic                   master_clear_n_o,   // device reset
  output logic                   write_strobe_n_o,   // write strobe
  output logic                   read_strobe_n_o,    // read strobe
  output logic                   first_load_rewind_n_o, // rewind pulse
  output logic                   cascade_in_n_o,     // mode select
  output logic [WORD_W-1:0]      push_word_o,        // data to device
  input  wire logic [WORD_W-1:0] pop_word_i,         // data from device
  input  wire logic              empty_flag_n_i,     // empty, low
  input  wire logic              full_flag_n_i,      // full, low
  input  wire logic              cascade_out_half_level_n_i // half, low
);
  //----------------------------------------------------------------
  // flag synchronisers: change counts when stages two and three agree
  //----------------------------------------------------------------
  logic [2:0] ef_s_reg;
  logic [2:0] ff_s_reg;
  logic [2:0] hf_s_reg;
  logic       ef_n_reg;
  logic       ff_n_reg;
  logic       hf_n_reg;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ef_s_reg <= 3'h0;
      ff_s_reg <= 3'h7;
      hf_s_reg <= 3'h7;
    end else begin
      ef_s_reg <= {ef_s_reg[1:0], empty_flag_n_i};
      ff_s_reg <= {ff_s_reg[1:0], full_flag_n_i};
      hf_s_reg <= {hf_s_reg[1:0], cascade_out_half_level_n_i};
    end
  end

  // flags start as empty asserted, full and half clear
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ef_n_reg <= 1'b0;
      ff_n_reg <= 1'b1;
      hf_n_reg <= 1'b1;
    end else begin
      if (ef_s_reg[1] == ef_s_reg[2]) begin
        ef_n_reg <= ef_s_reg[2];
      end
      if (ff_s_reg[1] == ff_s_reg[2]) begin
        ff_n_reg <= ff_s_reg[2];
      end
      if (hf_s_reg[1] == hf_s_reg[2]) begin
        hf_n_reg <= hf_s_reg[2];
      end
    end
  end

  //----------------------------------------------------------------
  // strobe sequencer
  //----------------------------------------------------------------
  anf_state_e             st_reg;
  logic [ANF_CNT_W-1:0]   tmr_reg;
  logic                   rew_reg;
  logic                   clr_pend_reg;
  logic                   rew_pend_reg;
  logic [WORD_W-1:0]      cap_reg;
  logic                   cap_vld_reg;
  logic                   buf_ready;
  logic                   tmr_done;
  logic                   can_wr;
  logic                   can_rd;

  assign tmr_done = (tmr_reg == ANF_CNT_W'(0));
  // strobe only while the flag allows the pointer to move
  assign can_wr = push_valid_i && ff_n_reg;
  // reads held off while empty; buffer room avoids word loss
  assign can_rd = ef_n_reg && buf_ready && !cap_vld_reg;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || clear_req_i) begin
      clr_pend_reg <= 1'b1;
    end else if (st_reg == ANF_ST_RESET && tmr_done) begin
      clr_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rew_pend_reg <= 1'b0;
    end else if (rewind_req_i) begin
      rew_pend_reg <= 1'b1;
    end else if (st_reg == ANF_ST_IDLE && !clr_pend_reg) begin
      rew_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_reg  <= ANF_ST_RESET;
      tmr_reg <= ANF_CNT_W'(ANF_RST_CYC);
      rew_reg <= 1'b0;
    end else begin
      case (st_reg)
        // device reset held before first write
        ANF_ST_RESET: begin
          if (!tmr_done) begin
            tmr_reg <= tmr_reg - ANF_ONE;
          end else begin
            st_reg  <= ANF_ST_HIGH;
            tmr_reg <= ANF_CNT_W'(ANF_STB_CYC);
          end
        end
        ANF_ST_IDLE: begin
          tmr_reg <= ANF_CNT_W'(ANF_STB_CYC);
          if (clr_pend_reg) begin
            st_reg  <= ANF_ST_RESET;
            tmr_reg <= ANF_CNT_W'(ANF_RST_CYC);
          end else if (rew_pend_reg && single_mode_i) begin
            // rewind issued only with both strobes idle
            st_reg  <= ANF_ST_HIGH;
            rew_reg <= 1'b1;
            tmr_reg <= ANF_CNT_W'(ANF_RST_CYC);
          // read and write strobes may fall together
          end else if (can_wr && can_rd) begin
            st_reg <= ANF_ST_RWLOW;
          end else if (can_wr) begin
            st_reg <= ANF_ST_WLOW;
          end else if (can_rd) begin
            st_reg <= ANF_ST_RLOW;
          end
        end
        ANF_ST_WLOW, ANF_ST_RLOW, ANF_ST_RWLOW: begin
          if (!tmr_done) begin
            tmr_reg <= tmr_reg - ANF_ONE;
          end else begin
            // stale flags would let a strobe hit an empty or full device
            st_reg  <= ANF_ST_HIGH;
            tmr_reg <= ANF_CNT_W'(ANF_STB_CYC + ANF_SYNC_CYC);
          end
        end
        ANF_ST_HIGH: begin
          if (!tmr_done) begin
            tmr_reg <= tmr_reg - ANF_ONE;
          end else begin
            st_reg  <= ANF_ST_IDLE;
            rew_reg <= 1'b0;
          end
        end
        default: begin
          st_reg <= ANF_ST_IDLE;
        end
      endcase
    end
  end

  //----------------------------------------------------------------
  // pins
  //----------------------------------------------------------------
  logic rd_end;
  logic wr_start;
  assign rd_end = (st_reg == ANF_ST_RLOW || st_reg == ANF_ST_RWLOW)
                  && tmr_done;
  assign wr_start = (st_reg == ANF_ST_IDLE) && !clr_pend_reg
                    && !(rew_pend_reg && single_mode_i) && can_wr;

  // both strobes high while reset and rewind are driven
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      master_clear_n_o      <= 1'b0;
      write_strobe_n_o      <= 1'b1;
      read_strobe_n_o       <= 1'b1;
      first_load_rewind_n_o <= 1'b1;
      cascade_in_n_o        <= 1'b0;
      push_word_o           <= '0;
    end else begin
      master_clear_n_o <= !(st_reg == ANF_ST_RESET && !tmr_done);
      // write strobe low while full flag is clear
      write_strobe_n_o <= !(st_reg == ANF_ST_WLOW ||
                            st_reg == ANF_ST_RWLOW) || tmr_done;
      // read strobe low opens the oldest word
      read_strobe_n_o  <= !(st_reg == ANF_ST_RLOW ||
                            st_reg == ANF_ST_RWLOW) || tmr_done;
      // expansion holds first-load low: this device is chain head
      first_load_rewind_n_o <= single_mode_i &&
                               !(rew_reg && st_reg == ANF_ST_HIGH &&
                                 !tmr_done);
      cascade_in_n_o   <= !single_mode_i;
      if (wr_start) begin
        push_word_o <= push_data_i;
      end
    end
  end

  // sample data before the read strobe rises and floats it
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cap_vld_reg <= 1'b0;
      cap_reg     <= '0;
    end else if (rd_end) begin
      cap_vld_reg <= 1'b1;
      cap_reg     <= pop_word_i;
    end else if (buf_ready) begin
      cap_vld_reg <= 1'b0;
    end
  end

  logic [WORD_W-1:0] buf_data;
  logic              buf_valid;

  anf_skid #(.W(WORD_W)) u_skid (
    .mclk_i      (mclk_i),
    .sys_rst_i   (sys_rst_i),
    .in_data_i   (cap_reg),
    .in_valid_i  (cap_vld_reg),
    .in_ready_o  (buf_ready),
    .out_data_o  (buf_data),
    .out_valid_o (buf_valid),
    .out_ready_i (pop_ready_i)
  );

  // outputs registered; pop outputs come from the buffer's own flops
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      push_ready_o <= 1'b0;
      empty_o      <= 1'b1;
      full_o       <= 1'b0;
      half_o       <= 1'b0;
      busy_o       <= 1'b1;
    end else begin
      push_ready_o <= wr_start;
      // empty and full flags seen by the user
      empty_o      <= !ef_n_reg;
      full_o       <= !ff_n_reg;
      // half level meaningful only in single mode
      half_o       <= !hf_n_reg && single_mode_i;
      busy_o       <= (st_reg != ANF_ST_IDLE);
    end
  end
  assign pop_data_o  = buf_data;
  assign pop_valid_o = buf_valid;
endmodule
`default_nettype wire

// >>> bench/anf_host_chk.sv
// checker for the host controller's device-side pins
`timescale 1ns/1ps
`default_nettype none
module anf_host_chk
  import anf_pkg::*;
#(
  parameter int unsigned WORD_W = ANF_WORD_W
) (
  input wire logic              mclk_i,                // clock
  input wire logic              sys_rst_i,             // sync reset
  input wire logic [WORD_W-1:0] push_data_i,           // user word
  input wire logic              push_ready_o,          // word taken
  input wire logic              single_mode_i,         // mode request
  input wire logic              master_clear_n_o,      // device reset
  input wire logic              write_strobe_n_o,      // write strobe
  input wire logic              read_strobe_n_o,       // read strobe
  input wire logic              first_load_rewind_n_o, // rewind
  input wire logic              cascade_in_n_o,        // mode pin
  input wire logic [WORD_W-1:0] push_word_o            // device data
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // the device only accepts writes once it has seen a reset
  logic seen_clr_reg;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      seen_clr_reg <= 1'b0;
    end else if (!master_clear_n_o) begin
      seen_clr_reg <= 1'b1;
    end
  end
  clr_strobe_idle_a: assert property (
    !master_clear_n_o |-> write_strobe_n_o && read_strobe_n_o)
    else $error("strobe active during device reset");
  rwd_strobe_idle_a: assert property (
    !first_load_rewind_n_o && !cascade_in_n_o
      |-> write_strobe_n_o && read_strobe_n_o)
    else $error("strobe active during rewind");
  mode_pin_a: assert property (
    $stable(single_mode_i) |=> cascade_in_n_o != $past(single_mode_i))
    else $error("cascade pin does not follow mode");
  wr_after_clr_a: assert property (
    !write_strobe_n_o |-> seen_clr_reg)
    else $error("write before any device reset");
  clr_width_a: assert property (
    $fell(master_clear_n_o) |-> !master_clear_n_o [*5])
    else $error("device reset pulse too short");
  wr_width_a: assert property (
    $fell(write_strobe_n_o) |-> !write_strobe_n_o [*2] ##1 write_strobe_n_o)
    else $error("write strobe width wrong");
  wr_take_a: assert property (
    push_ready_o |-> push_word_o == $past(push_data_i)
      ##1 $fell(write_strobe_n_o))
    else $error("word taken without matching strobe");
endmodule
bind anf_host anf_host_chk #(.WORD_W(WORD_W)) u_chk (
  .mclk_i, .sys_rst_i, .push_data_i, .push_ready_o, .single_mode_i,
  .master_clear_n_o, .write_strobe_n_o, .read_strobe_n_o,
  .first_load_rewind_n_o, .cascade_in_n_o, .push_word_o
);
`default_nettype wire

// >>> bench/anf_dev_model.sv
// behavioural nine-bit fifo device at the host's pins
`timescale 1ns/1ps
`default_nettype none
module anf_dev_model #(
  parameter int unsigned DEPTH = 8
) (
  input  wire logic       mr_n_i, // device reset
  input  wire logic       wr_n_i, // write strobe
  input  wire logic       rd_n_i, // read strobe
  input  wire logic       rt_n_i, // rewind
  input  wire logic       xi_n_i, // cascade in, low is single mode
  input  wire logic [8:0] d_i,    // push word
  output logic      [8:0] q_o,    // pop word
  output logic            ef_n_o, // empty
  output logic            ff_n_o, // full
  output logic            hf_n_o  // half
);
  logic [8:0] mem [DEPTH];
  int         wp = 0;
  int         rp = 0;
  int         cnt = 0;
  logic       wok = 1'b0;
  logic       rok = 1'b0;
  initial q_o = 9'h0aa;
  assign ef_n_o = (cnt != 0);
  assign ff_n_o = (cnt != DEPTH);
  // a write in progress counts from its falling edge
  // expansion: pulse while the last location is written
  assign hf_n_o = xi_n_i ? !(wok && !wr_n_i && wp == DEPTH - 1)
                         : !(cnt + int'(wok && !wr_n_i) > DEPTH / 2);
  // reset clears read pointer; write pointer unless later device
  always @(negedge mr_n_i) begin
    rp = 0;
    cnt = 0;
    if (!xi_n_i || !rt_n_i) wp = 0;
  end
  always @(negedge wr_n_i) begin
    wok = ff_n_o && mr_n_i;
    if (wok) mem[wp] = d_i;
  end
  always @(posedge wr_n_i) begin
    if (wok) begin
      wp = (wp + 1) % DEPTH;
      cnt++;
    end
    wok = 1'b0;
  end
  // oldest word only when not empty
  always @(negedge rd_n_i) begin
    rok = ef_n_o && mr_n_i;
    if (rok) q_o = mem[rp];
  end
  // released bus flips, read pointer wraps
  always @(posedge rd_n_i) begin
    if (rok) begin
      rp = (rp + 1) % DEPTH;
      cnt--;
    end
    rok = 1'b0;
    q_o = ~q_o;
  end
  // rewind keeps write pointer; assumes no wrap since reset
  // only in single mode; the delay lets the mode pin settle first
  always @(negedge rt_n_i) begin
    #1;
    if (!xi_n_i) begin
      rp = 0;
      cnt = wp;
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking testbench for the nine-bit fifo host controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned DEPTH = 8;
  logic       mclk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic [8:0] push_data_i = 9'h000;
  logic       push_valid_i = 1'b0;
  logic       pop_ready_i = 1'b0;
  logic       rewind_req_i = 1'b0;
  logic       clear_req_i = 1'b0;
  logic       single_mode_i = 1'b1;
  logic       push_ready_o, pop_valid_o, empty_o, full_o, half_o, busy_o;
  logic [8:0] pop_data_o, push_word_o, pop_word_i;
  logic       master_clear_n_o, write_strobe_n_o, read_strobe_n_o;
  logic       first_load_rewind_n_o, cascade_in_n_o;
  logic       empty_flag_n_i, full_flag_n_i, cascade_out_half_level_n_i;
  int         errors = 0;
  int         compares = 0;
  int         cyc = 0;
  logic [8:0] q [$];
  always #50 mclk_i = ~mclk_i;
  anf_host dut (
    .mclk_i, .sys_rst_i, .push_data_i, .push_valid_i, .push_ready_o,
    .pop_data_o, .pop_valid_o, .pop_ready_i, .rewind_req_i, .clear_req_i,
    .single_mode_i, .empty_o, .full_o, .half_o, .busy_o,
    .master_clear_n_o, .write_strobe_n_o, .read_strobe_n_o,
    .first_load_rewind_n_o, .cascade_in_n_o, .push_word_o, .pop_word_i,
    .empty_flag_n_i, .full_flag_n_i, .cascade_out_half_level_n_i
  );
  anf_dev_model #(.DEPTH(DEPTH)) u_dev (
    .mr_n_i(master_clear_n_o), .wr_n_i(write_strobe_n_o),
    .rd_n_i(read_strobe_n_o), .rt_n_i(first_load_rewind_n_o),
    .xi_n_i(cascade_in_n_o),
    .d_i(push_word_o), .q_o(pop_word_i), .ef_n_o(empty_flag_n_i),
    .ff_n_o(full_flag_n_i), .hf_n_o(cascade_out_half_level_n_i)
  );
  task automatic test_done();
    if (errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [8:0] exp, got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // flags pass a three-flop synchroniser, so give them time to land
  task automatic settle();
    int n;
    n = 0;
    repeat (8) @(posedge mclk_i);
    do begin
      @(negedge mclk_i);
      n++;
    end while (busy_o !== 1'b0 && n < 200);
    chk("idle", 1'b1, n < 200);
    @(posedge mclk_i);
  endtask
  task automatic push(input logic [8:0] w, output logic ok);
    int n;
    n = 0;
    @(posedge mclk_i);
    push_data_i <= w;
    push_valid_i <= 1'b1;
    do begin
      @(negedge mclk_i);
      n++;
    end while (push_ready_o !== 1'b1 && n < 60);
    ok = (n < 60);
    @(posedge mclk_i);
    push_valid_i <= 1'b0;
    if (ok) q.push_back(w);
  endtask
  task automatic pop(input string nm);
    int n;
    n = 0;
    @(posedge mclk_i);
    pop_ready_i <= 1'b1;
    do begin
      @(negedge mclk_i);
      n++;
    end while (pop_valid_o !== 1'b1 && n < 200);
    chk(nm, q.size() > 0 ? q.pop_front() : 9'h1ff, pop_data_o);
    @(posedge mclk_i);
    pop_ready_i <= 1'b0;
  endtask
  task automatic req(input bit rw);
    @(posedge mclk_i);
    if (rw) rewind_req_i <= 1'b1;
    else clear_req_i <= 1'b1;
    @(posedge mclk_i);
    rewind_req_i <= 1'b0;
    clear_req_i <= 1'b0;
    settle();
  endtask
  task automatic t_order();
    logic ok;
    for (int i = 0; i < 5; i++) begin
      push(9'(i * 97 + 3), ok);
      chk("push", 1'b1, ok);
    end
    for (int i = 0; i < 5; i++) pop("order");
  endtask
  task automatic t_full();
    logic ok;
    for (int i = 0; i < DEPTH + 2; i++) begin
      push(9'h100 ^ 9'(i * 29), ok);
      chk("fill", 1'b1, ok);
    end
    push(9'h0ff, ok);
    chk("refused", 1'b0, ok);
    settle();
    chk("full", 1'b1, full_o);
    chk("half", 1'b1, half_o);
    for (int i = 0; i < DEPTH + 2; i++) pop("drain");
    settle();
    chk("empty", 1'b1, empty_o);
    chk("half", 1'b0, half_o);
    chk("extra", 1'b0, pop_valid_o);
  endtask
  task automatic t_rewind();
    logic ok;
    req(1'b0);
    chk("clr empty", 1'b1, empty_o);
    for (int i = 0; i < 3; i++) begin
      push(9'h0a0 + 9'(i), ok);
      chk("push", 1'b1, ok);
    end
    for (int i = 0; i < 3; i++) pop("first");
    q = '{9'h0a0, 9'h0a1, 9'h0a2};
    req(1'b1);
    for (int i = 0; i < 3; i++) pop("replay");
  endtask
  task automatic t_mode();
    logic ok;
    single_mode_i <= 1'b0;
    settle();
    chk("cascade", 1'b1, cascade_in_n_o);
    chk("first load", 1'b0, first_load_rewind_n_o);
    push(9'h155, ok);
    chk("push", 1'b1, ok);
    pop("expand");
    req(1'b1);
    chk("no rewind", 1'b1, empty_o);
    single_mode_i <= 1'b1;
    settle();
    chk("cascade", 1'b0, cascade_in_n_o);
  endtask
  initial begin
    repeat (12) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    settle();
    chk("empty", 1'b1, empty_o);
    chk("full", 1'b0, full_o);
    chk("half", 1'b0, half_o);
    t_order();
    t_full();
    t_rewind();
    t_mode();
    test_done();
  end
endmodule
`default_nettype wire
